// ==== core/sram_host.v ====
// host controller driving a 1M x 16 asynchronous static memory by its pins
// assumes a single 100 MHz clock; data pins are split in/out/enable
`include "sram_host_defines.vh"

module sram_host #(
	parameter POWER_WAIT = `POWER_CYCLES
) (
	// clock and reset
	input  wire                clk_sys,
	input  wire                rstn,
	// user request
	input  wire                req_valid,
	input  wire                req_write,
	input  wire [`ADDR_W-1:0]  req_addr,
	input  wire [`DATA_W-1:0]  req_wdata,
	input  wire [1:0]          req_lanes,
	output reg                 req_ready_q,
	// user answer
	output reg                 rsp_valid_q,
	output reg  [`DATA_W-1:0]  rsp_rdata_q,
	// memory pins
	output reg  [`ADDR_W-1:0]  mem_addr_q,
	output reg                 select_a_n_q,
	output reg                 select_b_q,
	output reg                 output_gate_n_q,
	output reg                 write_strobe_n_q,
	output reg                 low_byte_lane_n_q,
	output reg                 upper_byte_lane_n_q,
	input  wire [`DATA_W-1:0]  mem_dq_i,
	output reg  [`DATA_W-1:0]  mem_dq_o_q,
	output reg  [1:0]          mem_dq_oe_q
);

localparam [4:0] S_POWER = 5'b00001;
localparam [4:0] S_IDLE  = 5'b00010;
localparam [4:0] S_READ  = 5'b00100;
localparam [4:0] S_WRITE = 5'b01000;
localparam [4:0] S_HOLD  = 5'b10000;

localparam [31:0] POWER_SPAN = POWER_WAIT - 1;
localparam [31:0] READ_SPAN  = `READ_CYCLES + 2;
localparam [31:0] WRITE_SPAN = `WRITE_CYCLES - 1;
localparam [31:0] HOLD_SPAN  = `HOLD_CYCLES - 1;
localparam [23:0] POWER_LAST = POWER_SPAN[23:0];
localparam [3:0]  READ_LAST  = READ_SPAN[3:0];
localparam [3:0]  WRITE_LAST = WRITE_SPAN[3:0];
localparam [3:0]  HOLD_LAST  = HOLD_SPAN[3:0];

reg  [4:0]         state_q;
reg  [23:0]        pwr_cnt_q;
reg  [3:0]         cnt_q;
reg  [1:0]         lanes_q;
wire [`DATA_W-1:0] rd_sync;
wire               lanes_any;
wire               take;
wire               busy;
wire               power_done;
wire               rd_done;
wire               wr_done;
wire               hold_done;
wire               end_access;

pin_sync3 u_sync (
	.clk_sys  (clk_sys),
	.rstn     (rstn),
	.pin_i    (mem_dq_i),
	.stable_q (rd_sync)
);

// ===================================================================
// keep only the lanes that were requested; the other byte reads as zero
function [`DATA_W-1:0] lane_mask;
	input [1:0] lanes;
	begin
		lane_mask = {{8{lanes[1]}}, {8{lanes[0]}}};
	end
endfunction

// ===================================================================
// decoded events; each done flag is true in the cycle that ends a phase
assign lanes_any  = |req_lanes;
assign take       = (state_q == S_IDLE) && req_valid && lanes_any;
assign busy       = (state_q & (S_READ | S_WRITE | S_HOLD)) != 5'b00000;
assign power_done = (state_q == S_POWER) && (pwr_cnt_q == POWER_LAST);
assign rd_done    = (state_q == S_READ) && (cnt_q == READ_LAST);
assign wr_done    = (state_q == S_WRITE) && (cnt_q == WRITE_LAST);
assign hold_done  = (state_q == S_HOLD) && (cnt_q == HOLD_LAST);
assign end_access = rd_done || hold_done;

// ===================================================================
// power-up wait: no access until the supply settle time has passed
always @(posedge clk_sys or negedge rstn) begin
	if (!rstn) begin
		pwr_cnt_q <= 24'h000000;
	end else if (state_q == S_POWER && !power_done) begin // see [RULE13]
		pwr_cnt_q <= pwr_cnt_q + 24'h000001;
	end
end

// ===================================================================
// access sequencer
// a write ends by its strobe and holds data one more cycle; a read
// waits for the three-stage pin filter before sampling
always @(posedge clk_sys or negedge rstn) begin
	if (!rstn) begin
		state_q <= S_POWER;
	end else begin
		case (state_q)
		S_POWER: begin
			if (power_done) begin // see [RULE13]
				state_q <= S_IDLE;
			end
		end
		S_IDLE: begin
			if (take && req_write) begin
				state_q <= S_WRITE;
			end else if (take) begin
				state_q <= S_READ;
			end
		end
		S_READ: begin
			if (rd_done) begin
				state_q <= S_IDLE;
			end
		end
		S_WRITE: begin
			if (wr_done) begin // see [RULE14]
				state_q <= S_HOLD;
			end
		end
		S_HOLD: begin
			if (hold_done) begin
				state_q <= S_IDLE;
			end
		end
		default: begin
			state_q <= S_IDLE;
		end
		endcase
	end
end

// ===================================================================
// phase counter: restarts at every take and again when the strobe ends
always @(posedge clk_sys or negedge rstn) begin
	if (!rstn) begin
		cnt_q <= 4'h0;
	end else if (take || wr_done) begin
		cnt_q <= 4'h0;
	end else if (busy && !rd_done && !hold_done) begin
		cnt_q <= cnt_q + 4'h1;
	end
end

// ===================================================================
// request handshake and read answer
always @(posedge clk_sys or negedge rstn) begin
	if (!rstn) begin
		req_ready_q <= 1'b0;
		rsp_valid_q <= 1'b0;
		rsp_rdata_q <= 16'h0000;
		lanes_q     <= 2'b00;
	end else begin
		rsp_valid_q <= rd_done;
		if (power_done || end_access) begin
			req_ready_q <= 1'b1;
		end else if (take) begin
			req_ready_q <= 1'b0;
		end
		if (take) begin
			lanes_q <= req_lanes;
		end
		if (rd_done) begin
			rsp_rdata_q <= rd_sync & lane_mask(lanes_q); // see [RULE8]
		end
	end
end

// ===================================================================
// control pins
always @(posedge clk_sys or negedge rstn) begin
	if (!rstn) begin
		mem_addr_q          <= 20'h00000;
		select_a_n_q        <= 1'b1;
		select_b_q          <= 1'b0;
		output_gate_n_q     <= 1'b1;
		write_strobe_n_q    <= 1'b1;
		low_byte_lane_n_q   <= 1'b1;
		upper_byte_lane_n_q <= 1'b1;
	end else if (take) begin
		mem_addr_q          <= req_addr;
		select_a_n_q        <= 1'b0; // see [RULE2]
		select_b_q          <= 1'b1;
		low_byte_lane_n_q   <= ~req_lanes[0];
		upper_byte_lane_n_q <= ~req_lanes[1];
		// gate stays high in a write so the device cannot drive into us
		output_gate_n_q     <= req_write; // see [RULE4] [RULE5]
		write_strobe_n_q    <= ~req_write; // see [RULE9] [RULE11]
	end else if (wr_done) begin
		// strobe alone ends the write; selects drop a cycle later
		write_strobe_n_q    <= 1'b1; // see [RULE10]
	end else if (end_access) begin
		output_gate_n_q     <= 1'b1;
		select_a_n_q        <= 1'b1; // see [RULE3]
		select_b_q          <= 1'b0;
		low_byte_lane_n_q   <= 1'b1;
		upper_byte_lane_n_q <= 1'b1;
	end
end

// ===================================================================
// write data drive: only the requested bytes are driven
always @(posedge clk_sys or negedge rstn) begin
	if (!rstn) begin
		mem_dq_o_q  <= 16'h0000;
		mem_dq_oe_q <= 2'b00;
	end else if (take && req_write) begin
		mem_dq_o_q  <= req_wdata;
		mem_dq_oe_q <= req_lanes; // see [RULE6] [RULE7]
	end else if (take || hold_done) begin
		mem_dq_oe_q <= 2'b00;
	end
end

endmodule

// ==== core/sram_host_defines.vh ====
// constants for the host controller of a 1M x 16 asynchronous static memory
// assumes a 100 MHz system clock; included by every core file
//
// Function
// [RULE1] memory is one mebiword of 16 bits, data split in two bytes
// [RULE2] device is selected only with select_a_n low and select_b high
// [RULE3] deselected device floats data and ignores gate, strobe and lanes
// [RULE4] read with only low lane drives low byte, high byte floats
// [RULE5] read with only upper lane drives high byte; both lanes drive both
// [RULE6] write with only low lane stores low byte, pins not driven
// [RULE7] write stores upper, or both, bytes; output gate ignored meanwhile
// [RULE8] data floats when gate high or that byte lane is off
// [RULE9] internal write lasts exactly the overlap of select, strobe, lane
// [RULE10] any of select, strobe or lane may end a write; time data to it
// [RULE11] host keeps write strobe high through every read cycle
// [RULE12] select ending with strobe rise keeps data floating
// [RULE13] host waits 100 us after power up before the first access
// [RULE14] strobe write with gate low lasts strobe-to-float plus data setup
// [RULE15] device model is combinational and keeps contents when deselected
`ifndef SRAM_HOST_DEFINES_VH
`define SRAM_HOST_DEFINES_VH

`define ADDR_W         20
`define DATA_W         16
`define CLK_PERIOD_NS  10

// ===================================================================
// timing figures, ns unless stated
`define T_POWER_US     100
`define T_RC_NS        10
`define T_AA_NS        10
`define T_HZWE_NS      5
`define T_SD_NS        5
`define T_PWE_NS       7
`define T_HD_NS        0

// ===================================================================
// derived cycle counts: minimums round up
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWER_CYCLES  ((`T_POWER_US * 1000) / `CLK_PERIOD_NS)
`define READ_CYCLES   (`CYC_UP(`T_AA_NS) + 1)
`define WRITE_CYCLES  (`CYC_UP(`T_HZWE_NS + `T_SD_NS) + 0)
`define HOLD_CYCLES   1

`endif

// ==== core/pin_sync3.v ====
// three-stage synchroniser bank for the returned data pins
// assumes input is asynchronous to clk_sys
`include "sram_host_defines.vh"

module pin_sync3 (
	// clock and reset
	input  wire                clk_sys,
	input  wire                rstn,
	// pins in, filtered value out
	input  wire [`DATA_W-1:0]  pin_i,
	output reg  [`DATA_W-1:0]  stable_q
);

reg [`DATA_W-1:0] s1_q;
reg [`DATA_W-1:0] s2_q;
reg [`DATA_W-1:0] s3_q;

// ===================================================================
// a bit changes only once stages two and three agree
always @(posedge clk_sys or negedge rstn) begin
	if (!rstn) begin
		s1_q     <= {`DATA_W{1'b0}};
		s2_q     <= {`DATA_W{1'b0}};
		s3_q     <= {`DATA_W{1'b0}};
		stable_q <= {`DATA_W{1'b0}};
	end else begin
		s1_q     <= pin_i;
		s2_q     <= s1_q;
		s3_q     <= s2_q;
		stable_q <= (s2_q & s3_q) | (stable_q & (s2_q ^ s3_q));
	end
end

endmodule

// ==== tb/sram_dev.sv ====
// behavioural 1M x 16 static memory on the host pins
// assumes pins settle combinationally; no clock
module sram_dev (
	input  wire logic [19:0] addr,
	input  wire logic        sel_a_n, sel_b, gate_n, strobe_n, lo_n, up_n,
	input  wire logic [15:0] din,
	output logic      [15:0] dout,
	output logic      [1:0]  dout_en
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:(1<<20)-1];
	wire sel = !sel_a_n && sel_b;
	// the strobe term keeps outputs off while the write strobe is low, even with the gate low
	wire rd = sel && !gate_n && strobe_n;
	always @* begin
		if (sel && !strobe_n && !lo_n) mem[addr][7:0] = din[7:0];
		if (sel && !strobe_n && !up_n) mem[addr][15:8] = din[15:8];
	end
	assign dout_en = {rd && !up_n, rd && !lo_n};
	assign dout = mem[addr];
endmodule

// ==== tb/sram_host_chk.sv ====
// checker on the request port and memory pins of the host
// assumes binding into sram_host, one clock domain
module sram_host_chk #(parameter POWER_WAIT = 4) (
	input wire logic        clk_sys, rstn, req_valid, req_write,
	input wire logic [1:0]  req_lanes, mem_dq_oe_q,
	input wire logic        req_ready_q, rsp_valid_q, select_a_n_q,
	input wire logic        select_b_q, output_gate_n_q, write_strobe_n_q,
	input wire logic        low_byte_lane_n_q, upper_byte_lane_n_q,
	input wire logic [15:0] mem_dq_o_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] up_q;
	wire take = req_ready_q && req_valid && req_lanes != 2'h0;
	always @(posedge clk_sys or negedge rstn)
		if (!rstn) up_q <= 16'h0;
		else if (up_q < POWER_WAIT) up_q <= up_q + 16'h1;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sel_pair_a: assert property (select_a_n_q == !select_b_q)
		else $error("selects disagree");
	power_wait_a: assert property (
		up_q < POWER_WAIT |-> select_a_n_q) else $error("access too early");
	read_strobe_a: assert property (
		!select_a_n_q && !output_gate_n_q |-> write_strobe_n_q)
		else $error("strobe low in read");
	no_fight_a: assert property (
		mem_dq_oe_q != 2'h0 |-> output_gate_n_q) else $error("bus contention");
	wr_lanes_a: assert property (!write_strobe_n_q |->
		!select_a_n_q &&
		mem_dq_oe_q == ~{upper_byte_lane_n_q, low_byte_lane_n_q})
		else $error("write lanes wrong");
	wr_hold_a: assert property (!write_strobe_n_q |=>
		$stable(mem_dq_o_q) && $stable(mem_dq_oe_q) && !select_a_n_q)
		else $error("no hold");
	rd_answer_a: assert property (take && !req_write |=>
		!req_ready_q [*5] ##1 rsp_valid_q) else $error("read answer late");
	wr_turn_a: assert property (take && req_write |=>
		!write_strobe_n_q ##1 write_strobe_n_q ##1 req_ready_q)
		else $error("write length");
endmodule
bind sram_host sram_host_chk #(.POWER_WAIT(POWER_WAIT)) chk_u (
	.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid),
	.req_write(req_write), .req_lanes(req_lanes), .mem_dq_oe_q(mem_dq_oe_q),
	.req_ready_q(req_ready_q), .rsp_valid_q(rsp_valid_q),
	.select_a_n_q(select_a_n_q), .select_b_q(select_b_q),
	.output_gate_n_q(output_gate_n_q), .write_strobe_n_q(write_strobe_n_q),
	.low_byte_lane_n_q(low_byte_lane_n_q),
	.upper_byte_lane_n_q(upper_byte_lane_n_q), .mem_dq_o_q(mem_dq_o_q));

// ==== tb/sram_host_tb.sv ====
// self-checking bench: host controller against the memory model
// assumes POWER_WAIT shortened to 4 cycles
module sram_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, rstn = 0, req_valid = 0, req_write = 0;
	logic [19:0] req_addr = 20'h0;
	logic [15:0] req_wdata = 16'h0;
	logic [1:0] req_lanes = 2'h0;
	wire req_ready_q, rsp_valid_q, select_a_n_q, select_b_q, output_gate_n_q;
	wire write_strobe_n_q, low_byte_lane_n_q, upper_byte_lane_n_q;
	wire [19:0] mem_addr_q;
	wire [15:0] rsp_rdata_q, mem_dq_i, mem_dq_o_q, dout;
	wire [1:0] mem_dq_oe_q, den;
	int miscompares = 0, n_checks = 0, cycles = 0;
	// undriven bytes show inverted data so a stray sample cannot pass
	assign mem_dq_i[7:0] = mem_dq_oe_q[0] ? mem_dq_o_q[7:0] :
		den[0] ? dout[7:0] : ~dout[7:0];
	assign mem_dq_i[15:8] = mem_dq_oe_q[1] ? mem_dq_o_q[15:8] :
		den[1] ? dout[15:8] : ~dout[15:8];
	sram_host #(.POWER_WAIT(4)) dut_u (.clk_sys(clk_sys), .rstn(rstn),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_lanes(req_lanes),
		.req_ready_q(req_ready_q), .rsp_valid_q(rsp_valid_q),
		.rsp_rdata_q(rsp_rdata_q), .mem_addr_q(mem_addr_q),
		.select_a_n_q(select_a_n_q), .select_b_q(select_b_q),
		.output_gate_n_q(output_gate_n_q),
		.write_strobe_n_q(write_strobe_n_q),
		.low_byte_lane_n_q(low_byte_lane_n_q),
		.upper_byte_lane_n_q(upper_byte_lane_n_q), .mem_dq_i(mem_dq_i),
		.mem_dq_o_q(mem_dq_o_q), .mem_dq_oe_q(mem_dq_oe_q));
	sram_dev dev_u (.addr(mem_addr_q), .sel_a_n(select_a_n_q),
		.sel_b(select_b_q), .gate_n(output_gate_n_q),
		.strobe_n(write_strobe_n_q), .lo_n(low_byte_lane_n_q),
		.up_n(upper_byte_lane_n_q), .din(mem_dq_o_q), .dout(dout),
		.dout_en(den));
	initial forever #5 clk_sys = ~clk_sys;
	task check(input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task results;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task op(input logic w, input logic [19:0] a, input logic [15:0] d,
		input logic [1:0] l);
		@(negedge clk_sys);
		{req_write, req_addr, req_wdata, req_lanes, req_valid} = {w, a, d, l, 1'b1};
		while (!req_ready_q) @(negedge clk_sys);
		@(negedge clk_sys);
		req_valid = 0;
		if (!w) while (!rsp_valid_q) @(negedge clk_sys);
		while (!req_ready_q) @(negedge clk_sys);
	endtask
	task rd(input logic [19:0] a, input logic [1:0] l, input logic [15:0] e);
		op(1'b0, a, 16'h0, l);
		check(rsp_rdata_q, e);
	endtask
	task t_lanes;
		op(1'b1, 20'h00005, 16'h1234, 2'h3);
		op(1'b1, 20'h00005, 16'hffab, 2'h1);
		op(1'b1, 20'h00005, 16'hcdff, 2'h2);
		rd(20'h00005, 2'h3, 16'hcdab);
		rd(20'h00005, 2'h1, 16'h00ab);
		rd(20'h00005, 2'h2, 16'hcd00);
	endtask
	task t_ends;
		op(1'b1, 20'hfffff, 16'h5a5a, 2'h3);
		op(1'b1, 20'h00000, 16'ha5a5, 2'h3);
		rd(20'hfffff, 2'h3, 16'h5a5a);
		rd(20'h00000, 2'h3, 16'ha5a5);
	endtask
	task t_idle;
		@(negedge clk_sys);
		{req_valid, req_write, req_lanes} = {1'b1, 1'b1, 2'h0};
		repeat (3) @(negedge clk_sys);
		req_valid = 0;
		check({15'h0, select_a_n_q}, 16'h1);
		check({15'h0, req_ready_q}, 16'h1);
	endtask
	// reset in mid-run: pins released, wait restarts, contents kept
	task t_reset;
		@(negedge clk_sys);
		rstn = 0;
		@(negedge clk_sys);
		check({13'h0, select_a_n_q, mem_dq_oe_q}, 16'h4);
		rstn = 1;
		repeat (3) @(negedge clk_sys);
		check({15'h0, req_ready_q}, 16'h0);
		@(negedge clk_sys);
		check({15'h0, req_ready_q}, 16'h1);
		rd(20'h00005, 2'h3, 16'hcdab);
	endtask
	initial begin
		repeat (8) @(negedge clk_sys);
		rstn = 1;
		check({15'h0, req_ready_q}, 16'h0);
		t_lanes;
		t_ends;
		t_idle;
		t_reset;
		results;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			results;
		end
	end
endmodule
